// File: tfe_channel.v
// Purpose: Per-channel event detection for capture (edge-aligned only), compare and PWM
// Assumes: Counter value and center-align select from the top
// Notes:   Output is a one-cycle event pulse
`default_nettype none
`include "tfe_defines.vh"
module tfe_channel (
   input  wire                   clk,
   input  wire                   reset_n,
   input  wire                   run,
   input  wire                   center_align_select,
   input  wire [1:0]             mode,
   input  wire                   edge_select_high_bit,
   input  wire                   edge_select_low_bit,
   input  wire [`TFE_CNT_W-1:0]  count,
   input  wire [`TFE_CNT_W-1:0]  value,
   input  wire                   chan_in,
   output reg                    event_q
);
   reg  in_q;
   wire rise  = chan_in & ~in_q;
   wire fall  = ~chan_in & in_q;
   wire match = run && (count == value);
   reg  edge_hit;

   always @* begin
      case ({edge_select_high_bit, edge_select_low_bit})
         `TFE_EDGE_RISE: edge_hit = rise;
         `TFE_EDGE_FALL: edge_hit = fall;
         `TFE_EDGE_ANY:  edge_hit = rise | fall;
         default:        edge_hit = 1'b0;
      endcase
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         in_q    <= 1'b0;
         event_q <= 1'b0;
      end else begin
         in_q <= chan_in;
         if (center_align_select)
            event_q <= (mode != `TFE_MODE_CAPT) && match;
         else case (mode)
            `TFE_MODE_CAPT: event_q <= edge_hit;
            `TFE_MODE_CMP:  event_q <= match;
            `TFE_MODE_EPWM: event_q <= match;
            default:        event_q <= match;
         endcase
      end
   end
endmodule // tfe_channel
`default_nettype wire

// File: tfe_defines.vh
// Purpose: Constants for the timer flag and event logic
// Assumes: 16-bit counter, two channels, word-wide register port
// Notes:   Offsets are word addresses on the plain register port
`ifndef TFE_DEFINES_VH
`define TFE_DEFINES_VH

`define TFE_CNT_W        16
`define TFE_CNT_ZERO     16'h0000
`define TFE_CNT_MAX      16'hFFFF
`define TFE_CNT_ONE      16'h0001
`define TFE_NCH          2
`define TFE_ADDR_W       4

// Register addresses
`define TFE_A_CTRL       4'h0
`define TFE_A_MOD        4'h1
`define TFE_A_COUNT      4'h2
`define TFE_A_STAT       4'h3
`define TFE_A_CH0_CTRL   4'h4
`define TFE_A_CH0_VAL    4'h5
`define TFE_A_CH1_CTRL   4'h6
`define TFE_A_CH1_VAL    4'h7

// Counter control fields
`define TFE_CTRL_RUN     0
`define TFE_CTRL_CAS     1
`define TFE_CTRL_WIE     2

// Status register: bit 0 wrap flag, bits 2:1 channel flags
`define TFE_STAT_WRAP    0
`define TFE_STAT_CH0     1

// Channel control fields
`define TFE_CH_ESL       0
`define TFE_CH_ESH       1
`define TFE_CH_MODE_LO   2
`define TFE_CH_MODE_HI   3
`define TFE_CH_IE        4

// Channel modes
`define TFE_MODE_CAPT    2'h0
`define TFE_MODE_CMP     2'h1
`define TFE_MODE_EPWM    2'h2

// Edge selects
`define TFE_EDGE_OFF     2'h0
`define TFE_EDGE_RISE    2'h1
`define TFE_EDGE_FALL    2'h2
`define TFE_EDGE_ANY     2'h3

`endif

// File: tfe_flag.v
// Purpose: One sticky event flag with read-then-write-zero clearing
// Assumes: Read strobe and write strobe qualified by the caller
// Notes:   A new event disarms a pending clear
`default_nettype none
module tfe_flag (
   input  wire clk,
   input  wire reset_n,
   input  wire set_evt,
   input  wire rd_seen,
   input  wire wr_zero,
   output reg  flag_q
);
   reg armed_q;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_q  <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         if (set_evt) begin
            flag_q  <= 1'b1;
            armed_q <= 1'b0;
         end else if (wr_zero && armed_q) begin
            flag_q  <= 1'b0;
            armed_q <= 1'b0;
         end else if (rd_seen && flag_q) begin
            armed_q <= 1'b1;
         end
      end
   end
endmodule // tfe_flag
`default_nettype wire

// File: tfe_timer.v
// Purpose: Timer flag and event logic top with register port
// Assumes: One 10 MHz clock, counter steps every enabled cycle
// Notes:   Flags clear only by read-then-write-zero of status
//
// Local design decisions: strobed register access and the address map.
`default_nettype none
`include "tfe_defines.vh"
module tfe_timer (
   input  wire                    clk,
   input  wire                    reset_n,
   input  wire [`TFE_ADDR_W-1:0]  addr,
   input  wire [15:0]             wdata,
   input  wire                    wr_en,
   input  wire                    rd_en,
   output reg  [15:0]             rdata_q,
   input  wire [`TFE_NCH-1:0]     chan_in,
   output wire                    wrap_irq,
   output wire [`TFE_NCH-1:0]     channel_irq
);
   ////////////////////////////////////////////////////////////////////
   reg  [2:0]             ctrl_q;
   reg  [`TFE_CNT_W-1:0]  mod_q;
   reg  [`TFE_CNT_W-1:0]  count_q;
   reg                    down_q;
   reg  [4:0]             chctl_q [0:`TFE_NCH-1];
   reg  [`TFE_CNT_W-1:0]  chval_q [0:`TFE_NCH-1];
   wire                   counter_wrap_flag;
   wire [`TFE_NCH-1:0]    channel_event_flag;
   wire [`TFE_NCH-1:0]    ch_evt;

   wire run                 = ctrl_q[`TFE_CTRL_RUN];
   wire center_align_select = ctrl_q[`TFE_CTRL_CAS];
   wire wrap_irq_enable     = ctrl_q[`TFE_CTRL_WIE];
   wire stat_rd             = rd_en && (addr == `TFE_A_STAT);
   wire stat_wr             = wr_en && (addr == `TFE_A_STAT);
   wire at_top = (mod_q == `TFE_CNT_ZERO) ? (count_q == `TFE_CNT_MAX) : (count_q == mod_q);

   ////////////////////////////////////////////////////////////////////
   // Counter; modulus zero in up/down mode is unsupported
   reg [`TFE_CNT_W-1:0] count_d;
   reg                  down_d;
   reg                  wrap_evt;
   always @* begin
      count_d  = count_q;
      down_d   = down_q;
      wrap_evt = 1'b0;
      if (run) begin
         if (!center_align_select) begin
            down_d = 1'b0;
            if (at_top) begin
               count_d  = `TFE_CNT_ZERO;
               wrap_evt = 1'b1;
            end else
               count_d = count_q + `TFE_CNT_ONE;
         end else if (!down_q) begin
            if (at_top) begin
               down_d   = 1'b1;
               count_d  = count_q - `TFE_CNT_ONE;
               wrap_evt = 1'b1;
            end else
               count_d = count_q + `TFE_CNT_ONE;
         end else begin
            if (count_q == `TFE_CNT_ZERO) begin
               down_d  = 1'b0;
               count_d = count_q + `TFE_CNT_ONE;
            end else
               count_d = count_q - `TFE_CNT_ONE;
         end
      end
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= `TFE_CNT_ZERO;
         down_q  <= 1'b0;
      end else if (wr_en && addr == `TFE_A_COUNT) begin
         count_q <= `TFE_CNT_ZERO;
         down_q  <= 1'b0;
      end else begin
         count_q <= count_d;
         down_q  <= down_d;
      end
   end

   // Wrap event registered so it aligns with channel events
   reg wrap_evt_q;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         wrap_evt_q <= 1'b0;
      else
         wrap_evt_q <= wrap_evt;
   end

   ////////////////////////////////////////////////////////////////////
   // Configuration registers
   integer i;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= 3'h0;
         mod_q  <= `TFE_CNT_ZERO;
         for (i = 0; i < `TFE_NCH; i = i + 1) begin
            chctl_q[i] <= 5'h00;
            chval_q[i] <= `TFE_CNT_ZERO;
         end
      end else if (wr_en) begin
         case (addr)
            `TFE_A_CTRL:     ctrl_q     <= wdata[2:0];
            `TFE_A_MOD:      mod_q      <= wdata;
            `TFE_A_CH0_CTRL: chctl_q[0] <= wdata[4:0];
            `TFE_A_CH0_VAL:  chval_q[0] <= wdata;
            `TFE_A_CH1_CTRL: chctl_q[1] <= wdata[4:0];
            `TFE_A_CH1_VAL:  chval_q[1] <= wdata;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Flags
   tfe_flag u_wrap_flag (
      .clk     (clk),
      .reset_n (reset_n),
      .set_evt (wrap_evt_q),
      .rd_seen (stat_rd),
      .wr_zero (stat_wr && !wdata[`TFE_STAT_WRAP]),
      .flag_q  (counter_wrap_flag)
   );

   genvar g;
   generate
      for (g = 0; g < `TFE_NCH; g = g + 1) begin : g_ch
         tfe_channel u_ch (
            .clk                  (clk),
            .reset_n              (reset_n),
            .run                  (run),
            .center_align_select  (center_align_select),
            .mode                 (chctl_q[g][`TFE_CH_MODE_HI:`TFE_CH_MODE_LO]),
            .edge_select_high_bit (chctl_q[g][`TFE_CH_ESH]),
            .edge_select_low_bit  (chctl_q[g][`TFE_CH_ESL]),
            .count                (count_q),
            .value                (chval_q[g]),
            .chan_in              (chan_in[g]),
            .event_q              (ch_evt[g])
         );
         tfe_flag u_ch_flag (
            .clk     (clk),
            .reset_n (reset_n),
            .set_evt (ch_evt[g]),
            .rd_seen (stat_rd),
            .wr_zero (stat_wr && !wdata[`TFE_STAT_CH0+g]),
            .flag_q  (channel_event_flag[g])
         );
         assign channel_irq[g] = channel_event_flag[g] & chctl_q[g][`TFE_CH_IE];
      end
   endgenerate

   assign wrap_irq = counter_wrap_flag & wrap_irq_enable;

   ////////////////////////////////////////////////////////////////////
   // Read port; unmapped addresses read zero
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         rdata_q <= 16'h0000;
      else if (rd_en) begin
         case (addr)
            `TFE_A_CTRL:     rdata_q <= {13'h0000, ctrl_q};
            `TFE_A_MOD:      rdata_q <= mod_q;
            `TFE_A_COUNT:    rdata_q <= count_q;
            `TFE_A_STAT:     rdata_q <= {12'h000, down_q, channel_event_flag, counter_wrap_flag};
            `TFE_A_CH0_CTRL: rdata_q <= {11'h000, chctl_q[0]};
            `TFE_A_CH0_VAL:  rdata_q <= chval_q[0];
            `TFE_A_CH1_CTRL: rdata_q <= {11'h000, chctl_q[1]};
            `TFE_A_CH1_VAL:  rdata_q <= chval_q[1];
            default:         rdata_q <= 16'h0000;
         endcase
      end else
         rdata_q <= 16'h0000;
   end
endmodule // tfe_timer
`default_nettype wire

// File: tfe_timer_asserts.sv
// Purpose: Port checker for the timer flag logic
// Assumes: Flags reach the ports only via irq and status
// Notes:   Irq may also drop when its enable is written
`default_nettype none
`include "tfe_defines.vh"
module tfe_chk (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic [3:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [15:0] rdata_q,
   input wire logic [1:0]  channel_irq,
   input wire logic        wrap_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////
   property p_rd_idle; !rd_en |=> rdata_q == 16'h0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_w_hold; $fell(wrap_irq) |-> $past(wr_en) && ($past(addr) == `TFE_A_STAT || $past(addr) == `TFE_A_CTRL);
   endproperty
   a_w_hold: assert property (p_w_hold) else $error("wrap irq dropped alone");
   property p_c0_hold; $fell(channel_irq[0]) |-> $past(wr_en) && $past(addr) inside {`TFE_A_STAT, `TFE_A_CH0_CTRL};
   endproperty
   a_c0_hold: assert property (p_c0_hold) else $error("ch0 irq dropped alone");
   property p_c1_hold; $fell(channel_irq[1]) |-> $past(wr_en) && $past(addr) inside {`TFE_A_STAT, `TFE_A_CH1_CTRL};
   endproperty
   a_c1_hold: assert property (p_c1_hold) else $error("ch1 irq dropped alone");
   property p_w_rd; rd_en && addr == `TFE_A_STAT && wrap_irq |=> rdata_q[0]; endproperty
   a_w_rd: assert property (p_w_rd) else $error("wrap irq without flag");
   property p_c_rd; rd_en && addr == `TFE_A_STAT |=> (rdata_q[2:1] & $past(channel_irq)) == $past(channel_irq);
   endproperty
   a_c_rd: assert property (p_c_rd) else $error("channel irq without flag");
   property p_w_one; wr_en && addr == `TFE_A_STAT && wdata[0] && wrap_irq |=> wrap_irq; endproperty
   a_w_one: assert property (p_w_one) else $error("one write cleared wrap");
   property p_c_one; wr_en && addr == `TFE_A_STAT && wdata[2:1] == 2'h3 |=> $past(channel_irq) == (channel_irq & $past(channel_irq));
   endproperty
   a_c_one: assert property (p_c_one) else $error("one write cleared channel");
endmodule // tfe_chk
bind tfe_timer tfe_chk tfe_chk_i (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
   .rd_en(rd_en), .rdata_q(rdata_q), .channel_irq(channel_irq), .wrap_irq(wrap_irq));
`default_nettype wire

// File: tfe_timer_tb.sv
// Purpose: Self-checking bench for the timer flag logic
// Assumes: Free-run wrap needs about 65536 cycles
// Notes:   Reads are two cycles apart, so counts step twice
`default_nettype none
`include "tfe_defines.vh"
module tfe_timer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [15:0] md; logic ca; logic [15:0] cc, cv, es;} tfe_row_t;
   tfe_row_t rows [4] = '{'{16'h0005, 1'b0, 16'h0014, 16'h0002, 16'h0003},
      '{16'h0005, 1'b0, 16'h0014, 16'h0009, 16'h0001}, '{16'h0004, 1'b1, 16'h0018, 16'h0002, 16'h0003},
      '{16'h0005, 1'b0, 16'h0018, 16'h0003, 16'h0003}};
   logic clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, dn, cs;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000, d, c, top;
   logic [1:0] chan_in = 2'h0;
   wire logic [15:0] rdata_q;
   wire logic wrap_irq;
   wire logic [1:0] channel_irq;
   int error_cnt = 0, n_tests = 0, k;
   always #50 clk = ~clk;
   tfe_timer tfe_timer_i (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .rdata_q(rdata_q), .chan_in(chan_in), .wrap_irq(wrap_irq), .channel_irq(channel_irq));
   ////////////////////////////////////////////////////////////
   task wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a; wdata <= v; wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask
   task rd(input logic [3:0] a);
      @(posedge clk);
      addr <= a; rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rdata_q;
   endtask
   task clr;
      rd(`TFE_A_STAT);
      wr(`TFE_A_STAT, 16'h0000);
   endtask
   task chk(input logic [15:0] g, e);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task pulse(input logic v);
      @(posedge clk);
      chan_in[1] <= v;
      repeat (4) @(posedge clk);
   endtask
   // Step model of the counter, up or up/down
   task adv;
      if (cs && !dn && c == top) dn = 1'b1;
      else if (cs && dn && c == 16'h0000) dn = 1'b0;
      if (dn) c = c - 16'h0001;
      else if (!cs && c == top) c = 16'h0000;
      else c = c + 16'h0001;
   endtask
   task end_sim;
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      #(80000 * 100);
      error_cnt++;
      end_sim;
   end
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      rd(`TFE_A_CTRL);
      chk(d, 16'h0000);
      rd(`TFE_A_STAT);
      chk(d, 16'h0000);
      chk({13'h0000, channel_irq, wrap_irq}, 16'h0000);
      rd(4'hF);
      chk(d, 16'h0000);
      $display("reset done");
      foreach (rows[i]) begin
         wr(`TFE_A_CTRL, 16'h0004);
         clr;
         wr(`TFE_A_CH0_CTRL, rows[i].cc);
         wr(`TFE_A_CH0_VAL, rows[i].cv);
         wr(`TFE_A_MOD, rows[i].md);
         wr(`TFE_A_COUNT, 16'h0000);
         wr(`TFE_A_CTRL, {13'h0000, 1'b1, rows[i].ca, 1'b1});
         top = rows[i].md;
         cs = rows[i].ca;
         dn = 1'b0;
         rd(`TFE_A_COUNT);
         c = d;
         repeat (8) begin
            adv;
            adv;
            rd(`TFE_A_COUNT);
            chk(d, c);
         end
         wr(`TFE_A_CTRL, 16'h0004);
         rd(`TFE_A_STAT);
         chk(d & 16'h0007, rows[i].es);
         chk({13'h0000, channel_irq, wrap_irq}, rows[i].es);
         $display("row %0d done", i);
      end
      // Ones written to status must not clear, even when armed
      wr(`TFE_A_STAT, 16'h0007);
      chk({15'h0000, wrap_irq}, 16'h0001);
      clr;
      chk({13'h0000, channel_irq, wrap_irq}, 16'h0000);
      $display("clear done");
      wr(`TFE_A_CH0_CTRL, 16'h0000);
      for (int e = 0; e < 4; e++) begin
         wr(`TFE_A_CH1_CTRL, 16'h0010 | e);
         clr;
         pulse(1'b1);
         rd(`TFE_A_STAT);
         chk({15'h0000, d[2]}, 16'(e == 1 || e == 3));
         chk({15'h0000, channel_irq[1]}, 16'(e == 1 || e == 3));
         clr;
         pulse(1'b0);
         rd(`TFE_A_STAT);
         chk({15'h0000, d[2]}, 16'(e >= 2));
      end
      clr;
      pulse(1'b1);
      rd(`TFE_A_STAT);
      pulse(1'b0);
      wr(`TFE_A_STAT, 16'h0000);
      chk({15'h0000, channel_irq[1]}, 16'h0001);
      $display("capture done");
      clr;
      wr(`TFE_A_MOD, 16'h0000);
      wr(`TFE_A_COUNT, 16'h0000);
      wr(`TFE_A_CTRL, 16'h0005);
      for (k = 0; k < 70000 && wrap_irq !== 1'b1; k++) @(posedge clk);
      rd(`TFE_A_COUNT);
      chk({15'h0000, d < 16'h0008}, 16'h0001);
      chk({15'h0000, k > 65000}, 16'h0001);
      $display("free run done");
      end_sim;
   end
endmodule // tfe_timer_tb
`default_nettype wire
